// *** hdl/mdsf_defines.svh ***
`ifndef MDSF_DEFINES_SVH
`define MDSF_DEFINES_SVH
// Register address of the status word
`define MDSF_ADDR_STATUS 7'h6f
// Status word bit positions
`define MDSF_BIT_STANDSTILL 31
`define MDSF_BIT_OPEN_B 30
`define MDSF_BIT_OPEN_A 29
`define MDSF_BIT_GND_B 28
`define MDSF_BIT_GND_A 27
`define MDSF_BIT_PREWARN 26
`define MDSF_BIT_THERMAL 25
`define MDSF_BIT_STALL 24
`define MDSF_RSV_HI 23
`define MDSF_RSV_LO 21
`define MDSF_CS_HI 20
`define MDSF_CS_LO 16
`define MDSF_BIT_FULLSTEP 15
`define MDSF_BIT_QUIET 14
`define MDSF_BIT_SUP_B 13
`define MDSF_BIT_SUP_A 12
// Standstill timeout in clocks
`define MDSF_STST_CLKS 32'h0010_0000
// Index of each pin input in the synchroniser vector
`define MDSF_IN_STEP 0
`define MDSF_IN_ENN 1
`define MDSF_IN_OPEN_A 2
`define MDSF_IN_OPEN_B 3
`define MDSF_IN_GND_A 4
`define MDSF_IN_GND_B 5
`define MDSF_IN_PREWARN 6
`define MDSF_IN_THERMAL 7
`define MDSF_NUM_PINS 8
// Reset values
`define MDSF_RST_WORD 32'h0000_0000
`define MDSF_RST_SYNC 8'h02
`endif

// *** hdl/mdsf_pkg.sv ***
package mdsf_pkg;
  // Live current scale field
  typedef logic [4:0] mdsf_cs_t;
  // Load measurement result
  typedef logic [9:0] mdsf_load_t;
  // One register word
  typedef logic [31:0] mdsf_word_t;
  // Drop measurement sample
  typedef logic [7:0] mdsf_drop_t;
  // Per-phase flag pair, bit 0 phase A, bit 1 phase B
  typedef logic [1:0] mdsf_pair_t;
endpackage

// *** hdl/mdsf_status.sv ***
`include "mdsf_defines.svh"
`timescale 1ns/1ns
module mdsf_status #(
  parameter int STST_CLKS = `MDSF_STST_CLKS, // Idle clocks to standstill
  parameter int SUP_THR = 200, // Supply short threshold, drop units
  parameter int OFF_W = 4 // Off-time setting width
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic step_pin,
  input wire logic driver_enable_n_pin,
  input wire logic open_raw_a,
  input wire logic open_raw_b,
  input wire logic gnd_raw_a,
  input wire logic gnd_raw_b,
  input wire logic prewarn_raw,
  input wire logic thermal_raw,
  input wire logic [OFF_W-1:0] off_time_setting,
  input wire mdsf_pkg::mdsf_drop_t hs_drop_a,
  input wire mdsf_pkg::mdsf_drop_t hs_drop_b,
  input wire mdsf_pkg::mdsf_drop_t sense_drop_a,
  input wire mdsf_pkg::mdsf_drop_t sense_drop_b,
  input wire mdsf_pkg::mdsf_load_t load_measure_value,
  input wire logic speed_mode_on,
  input wire logic speed_mode_stall,
  input wire mdsf_pkg::mdsf_cs_t cs_actual,
  input wire logic fullstep_on,
  input wire logic quiet_mode_on,
  input wire logic [6:0] reg_addr,
  input wire logic reg_rd,
  output logic [31:0] rd_data,
  output logic rd_valid,
  output logic bridge_disable
);

  // Pin inputs gathered for one synchroniser loop
  logic [`MDSF_NUM_PINS-1:0] pin_raw;
  // First synchroniser stage, read only by the second
  logic [`MDSF_NUM_PINS-1:0] meta;
  // Second synchroniser stage, safe to use
  logic [`MDSF_NUM_PINS-1:0] pin_s;
  // Previous step level for edge detection
  logic step_prev;
  logic next_step_prev;

  assign pin_raw = {thermal_raw, prewarn_raw, gnd_raw_b, gnd_raw_a,
                    open_raw_b, open_raw_a, driver_enable_n_pin, step_pin};

  // Two flops per pin; enable pin resets high so driver starts disabled
  genvar gi;
  generate
    for (gi = 0; gi < `MDSF_NUM_PINS; gi++) begin : g_sync
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          meta[gi] <= 1'(`MDSF_RST_SYNC >> gi);
          pin_s[gi] <= 1'(`MDSF_RST_SYNC >> gi);
        end else begin
          meta[gi] <= pin_raw[gi];
          pin_s[gi] <= meta[gi];
        end
      end
    end
  endgenerate

  // Step edge is taken from the second stage and its delayed copy
  logic step_edge;
  assign step_edge = pin_s[`MDSF_IN_STEP] & ~step_prev;
  // Driver counts as disabled by zero off-time or the enable pin
  logic drv_off;
  assign drv_off = (off_time_setting == '0) | pin_s[`MDSF_IN_ENN];
  // Standstill counter, saturates so it never wraps into a false step
  logic [31:0] idle_cnt;
  logic [31:0] next_idle_cnt;
  logic standstill;
  logic next_standstill;

  always_comb begin
    next_step_prev = pin_s[`MDSF_IN_STEP];
    next_idle_cnt = idle_cnt;
    next_standstill = standstill;
    if (step_edge) begin
      // Fresh step restarts the idle interval
      next_idle_cnt = 32'h0000_0000;
      next_standstill = 1'b0;
    end else if (idle_cnt < 32'(STST_CLKS - 1)) begin
      next_idle_cnt = idle_cnt + 32'h0000_0001;
    end else begin
      // Timeout reached in any mode
      next_idle_cnt = 32'(STST_CLKS - 1);
      next_standstill = 1'b1;
    end
  end
  // Standstill registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      step_prev <= 1'b0;
      idle_cnt <= 32'h0000_0000;
      standstill <= 1'b0;
    end else begin
      step_prev <= next_step_prev;
      idle_cnt <= next_idle_cnt;
      standstill <= next_standstill;
    end
  end

  // Supply short compare includes the sense resistor drop
  mdsf_pkg::mdsf_pair_t sup_det;
  logic [8:0] sup_sum_a;
  logic [8:0] sup_sum_b;
  assign sup_sum_a = {1'b0, hs_drop_a} + {1'b0, sense_drop_a};
  assign sup_sum_b = {1'b0, hs_drop_b} + {1'b0, sense_drop_b};
  assign sup_det = {sup_sum_b > 9'(SUP_THR), sup_sum_a > 9'(SUP_THR)};
  // Ground detections per phase from synchronised comparators
  mdsf_pkg::mdsf_pair_t gnd_det;
  assign gnd_det = {pin_s[`MDSF_IN_GND_B], pin_s[`MDSF_IN_GND_A]};
  // Latched short flags per phase
  mdsf_pkg::mdsf_pair_t gnd_short;
  mdsf_pkg::mdsf_pair_t next_gnd_short;
  mdsf_pkg::mdsf_pair_t sup_short;
  mdsf_pkg::mdsf_pair_t next_sup_short;
  // Two latches per phase, ground and supply; a detection wins over a clear in the same cycle
  generate
    for (gi = 0; gi < 2; gi++) begin : g_short
      always_comb begin
        next_gnd_short[gi] = gnd_short[gi];
        next_sup_short[gi] = sup_short[gi];
        if (gnd_det[gi]) begin
          next_gnd_short[gi] = 1'b1;
        end else if (drv_off) begin
          next_gnd_short[gi] = 1'b0;
        end
        if (sup_det[gi]) begin
          next_sup_short[gi] = 1'b1;
        end else if (drv_off) begin
          next_sup_short[gi] = 1'b0;
        end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          gnd_short[gi] <= 1'b0;
          sup_short[gi] <= 1'b0;
        end else begin
          gnd_short[gi] <= next_gnd_short[gi];
          sup_short[gi] <= next_sup_short[gi];
        end
      end
    end
  endgenerate

  // Shared thermal flag, held until both temperature signals drop
  logic thermal_flag;
  logic next_thermal_flag;
  always_comb begin
    next_thermal_flag = thermal_flag;
    if (pin_s[`MDSF_IN_THERMAL]) begin
      next_thermal_flag = 1'b1;
    end else if (!pin_s[`MDSF_IN_PREWARN]) begin
      // Cooling below prewarning releases the lockout
      next_thermal_flag = 1'b0;
    end
  end
  // Thermal register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      thermal_flag <= 1'b0;
    end else begin
      thermal_flag <= next_thermal_flag;
    end
  end

  // Stall is a live level; zero load means highest load
  logic stall_flag;
  logic next_stall_flag;
  // Registered copies of live indications, sampled once a clock
  logic [4:0] cs_q;
  logic [4:0] next_cs_q;
  logic fullstep_q;
  logic next_fullstep_q;
  logic quiet_q;
  logic next_quiet_q;
  always_comb begin
    next_stall_flag = (load_measure_value == '0)
                      | (speed_mode_on & speed_mode_stall);
    next_cs_q = cs_actual;
    next_fullstep_q = fullstep_on;
    next_quiet_q = quiet_mode_on;
  end
  // Live indication registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stall_flag <= 1'b0;
      cs_q <= 5'h00;
      fullstep_q <= 1'b0;
      quiet_q <= 1'b0;
    end else begin
      stall_flag <= next_stall_flag;
      cs_q <= next_cs_q;
      fullstep_q <= next_fullstep_q;
      quiet_q <= next_quiet_q;
    end
  end

  // Bridge off on any short or thermal lockout; open load plays no part
  assign bridge_disable = (|gnd_short) | (|sup_short) | thermal_flag;
  // Status word assembly
  mdsf_pkg::mdsf_word_t status_word;
  always_comb begin
    status_word = `MDSF_RST_WORD;
    status_word[`MDSF_BIT_STANDSTILL] = standstill;
    status_word[`MDSF_BIT_OPEN_B] = pin_s[`MDSF_IN_OPEN_B];
    status_word[`MDSF_BIT_OPEN_A] = pin_s[`MDSF_IN_OPEN_A];
    status_word[`MDSF_BIT_GND_B] = gnd_short[1];
    status_word[`MDSF_BIT_GND_A] = gnd_short[0];
    status_word[`MDSF_BIT_PREWARN] = pin_s[`MDSF_IN_PREWARN];
    status_word[`MDSF_BIT_THERMAL] = thermal_flag;
    status_word[`MDSF_BIT_STALL] = stall_flag;
    // Reserved bits stay at the zero default
    status_word[`MDSF_CS_HI:`MDSF_CS_LO] = cs_q;
    status_word[`MDSF_BIT_FULLSTEP] = fullstep_q;
    status_word[`MDSF_BIT_QUIET] = quiet_q;
    status_word[`MDSF_BIT_SUP_B] = sup_short[1];
    status_word[`MDSF_BIT_SUP_A] = sup_short[0];
  end

  // Read port; there is no write path, so writes cannot change anything
  logic [31:0] next_rd_data;
  logic next_rd_valid;
  always_comb begin
    next_rd_valid = reg_rd;
    next_rd_data = 32'h0000_0000;
    if (reg_rd && reg_addr == `MDSF_ADDR_STATUS) begin
      next_rd_data = status_word;
    end
  end

  // Read registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 32'h0000_0000;
      rd_valid <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  // No step edge in a cycle where the idle count already sits at the timeout value
  sequence s_idle_to_timeout;
    !step_edge && idle_cnt == 32'(STST_CLKS - 1);
  endsequence
  property p_stst_set;
    @(posedge mclk) disable iff (!rst_n)
      s_idle_to_timeout |=> standstill;
  endproperty
  a_stst_set: assert property (p_stst_set) else $error("standstill not set");
  property p_stst_clear;
    @(posedge mclk) disable iff (!rst_n)
      step_edge |=> !standstill && idle_cnt == 32'h0000_0000;
  endproperty
  a_stst_clear: assert property (p_stst_clear) else $error("step kept standstill");
  property p_stst_early;
    @(posedge mclk) disable iff (!rst_n)
      $rose(standstill) |-> $past(idle_cnt) == 32'(STST_CLKS - 1);
  endproperty
  a_stst_early: assert property (p_stst_early) else $error("standstill early");
  property p_gnd_latch;
    @(posedge mclk) disable iff (!rst_n)
      gnd_det[0] ##1 (!gnd_det[0] && !drv_off) [*2] |-> gnd_short[0];
  endproperty
  a_gnd_latch: assert property (p_gnd_latch) else $error("ground short lost");
  property p_sup_clear;
    @(posedge mclk) disable iff (!rst_n)
      drv_off && sup_det == 2'b00 |=> sup_short == 2'b00;
  endproperty
  a_sup_clear: assert property (p_sup_clear) else $error("supply short stuck");
  property p_short_off;
    @(posedge mclk) disable iff (!rst_n)
      (gnd_det[1] || sup_det[1]) |=> bridge_disable;
  endproperty
  a_short_off: assert property (p_short_off) else $error("bridge not disabled");
  // Lockout still set while the overtemperature input has just dropped
  sequence s_hot_then_warm;
    thermal_flag && $fell(pin_s[`MDSF_IN_THERMAL]) && pin_s[`MDSF_IN_PREWARN];
  endsequence
  property p_ot_hold;
    @(posedge mclk) disable iff (!rst_n)
      s_hot_then_warm |=> thermal_flag && bridge_disable;
  endproperty
  a_ot_hold: assert property (p_ot_hold) else $error("thermal released early");
  property p_ot_release;
    @(posedge mclk) disable iff (!rst_n)
      !pin_s[`MDSF_IN_THERMAL] && !pin_s[`MDSF_IN_PREWARN] |=> !thermal_flag;
  endproperty
  a_ot_release: assert property (p_ot_release) else $error("thermal not released");
  // A rise of the disable must trace back to a short or overtemperature detection
  property p_open_passive;
    @(posedge mclk) disable iff (!rst_n)
      $rose(bridge_disable) |-> $past(gnd_det != 2'b00 || sup_det != 2'b00
        || pin_s[`MDSF_IN_THERMAL]);
  endproperty
  a_open_passive: assert property (p_open_passive) else $error("spurious disable");
  property p_stall;
    @(posedge mclk) disable iff (!rst_n)
      load_measure_value == '0 |=> stall_flag;
  endproperty
  a_stall: assert property (p_stall) else $error("stall not flagged");
  property p_read;
    @(posedge mclk) disable iff (!rst_n)
      reg_rd && reg_addr == `MDSF_ADDR_STATUS |=> rd_valid
        && rd_data[`MDSF_BIT_THERMAL] == $past(thermal_flag)
        && rd_data[`MDSF_CS_HI:`MDSF_CS_LO] == $past(cs_q);
  endproperty
  a_read: assert property (p_read) else $error("status read wrong");
  property p_reserved;
    @(posedge mclk) disable iff (!rst_n)
      rd_valid |-> rd_data[`MDSF_RSV_HI:`MDSF_RSV_LO] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ns
`include "mdsf_defines.svh"
module tb_top;
  logic mclk = 1'b0; // Device clock, 4 ns period
  logic rst_n = 1'b0; // Held low at start
  logic step_pin = 1'b0, driver_enable_n_pin = 1'b0;
  logic open_raw_a = 1'b0, open_raw_b = 1'b0, gnd_raw_a = 1'b0, gnd_raw_b = 1'b0;
  logic prewarn_raw = 1'b0, thermal_raw = 1'b0;
  logic [3:0] off_time_setting = 4'h5; // Nonzero keeps the driver enabled
  mdsf_pkg::mdsf_drop_t hs_drop_a = 8'h00, hs_drop_b = 8'h00;
  mdsf_pkg::mdsf_drop_t sense_drop_a = 8'h00, sense_drop_b = 8'h00;
  mdsf_pkg::mdsf_load_t load_measure_value = 10'h3ff; // Nonzero, no stall yet
  logic speed_mode_on = 1'b0, speed_mode_stall = 1'b0, fullstep_on = 1'b0, quiet_mode_on = 1'b0;
  mdsf_pkg::mdsf_cs_t cs_actual = 5'h00;
  logic [6:0] reg_addr = 7'h00;
  logic reg_rd = 1'b0;
  logic [31:0] rd_data;
  logic rd_valid, bridge_disable;
  int num_errors = 0, checks = 0;
  logic [31:0] r = 32'he22d893d; // Random state
  logic [3:0] lat_sh = 4'h0; // Expected short latches: gnd a, gnd b, sup a, sup b
  logic lat_ot = 1'b0; // Expected thermal latch
  logic stst = 1'b0; // Expected standstill flag
  // Short count so standstill is reachable in a short run
  mdsf_status #(.STST_CLKS(16)) dut (.mclk(mclk), .rst_n(rst_n), .step_pin(step_pin),
    .driver_enable_n_pin(driver_enable_n_pin), .open_raw_a(open_raw_a), .open_raw_b(open_raw_b),
    .gnd_raw_a(gnd_raw_a), .gnd_raw_b(gnd_raw_b), .prewarn_raw(prewarn_raw),
    .thermal_raw(thermal_raw), .off_time_setting(off_time_setting), .hs_drop_a(hs_drop_a),
    .hs_drop_b(hs_drop_b), .sense_drop_a(sense_drop_a), .sense_drop_b(sense_drop_b),
    .load_measure_value(load_measure_value), .speed_mode_on(speed_mode_on),
    .speed_mode_stall(speed_mode_stall), .cs_actual(cs_actual), .fullstep_on(fullstep_on),
    .quiet_mode_on(quiet_mode_on), .reg_addr(reg_addr), .reg_rd(reg_rd), .rd_data(rd_data),
    .rd_valid(rd_valid), .bridge_disable(bridge_disable));
  // Free-running clock
  always #2 mclk = ~mclk;
  // Galois shift register, fixed seed keeps runs repeatable
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction
  // Status word expected from the bench's own view of inputs and latches
  function automatic logic [31:0] exp_word();
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`MDSF_BIT_STANDSTILL] = stst;
    w[`MDSF_BIT_OPEN_B] = open_raw_b;
    w[`MDSF_BIT_OPEN_A] = open_raw_a;
    w[`MDSF_BIT_GND_B] = lat_sh[1];
    w[`MDSF_BIT_GND_A] = lat_sh[0];
    w[`MDSF_BIT_PREWARN] = prewarn_raw;
    w[`MDSF_BIT_THERMAL] = lat_ot;
    w[`MDSF_BIT_STALL] = (load_measure_value == 10'h000) || (speed_mode_on && speed_mode_stall);
    w[`MDSF_CS_HI:`MDSF_CS_LO] = cs_actual;
    w[`MDSF_BIT_FULLSTEP] = fullstep_on;
    w[`MDSF_BIT_QUIET] = quiet_mode_on;
    w[`MDSF_BIT_SUP_B] = lat_sh[3];
    w[`MDSF_BIT_SUP_A] = lat_sh[2];
    return w;
  endfunction
  // One comparison, counted, reported at once on mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Single read: strobe for one cycle, answer stands only in the next one
  task automatic rd(input logic [6:0] a, input logic [31:0] exp);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk({31'h0, rd_valid}, 32'h1, "read valid");
    chk(rd_data, exp, "read data");
  endtask
  // Detection stimulus for one short kind; supply low level sits exactly on threshold
  task automatic set_det(input int k, input logic v);
    case (k)
      0: gnd_raw_a = v;
      1: gnd_raw_b = v;
      2: begin
        hs_drop_a = 8'h96;
        sense_drop_a = v ? 8'h33 : 8'h32;
      end
      default: begin
        hs_drop_b = 8'h96;
        sense_drop_b = v ? 8'h33 : 8'h32;
      end
    endcase
  endtask
  // Disable the driver by off-time for even kinds, by the pin for odd kinds
  task automatic drv_off(input int k, input logic v);
    if (k[0]) driver_enable_n_pin = v;
    else off_time_setting = v ? 4'h0 : 4'h5;
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Watchdog, well beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
  initial begin
    cyc(4);
    chk({30'h0, rd_valid, bridge_disable}, 32'h0, "reset outputs");
    rst_n = 1'b1;
    rd(`MDSF_ADDR_STATUS, exp_word());
    rd(7'h6e, 32'h0);
    rd(7'h00, 32'h0);
    cyc(20);
    stst = 1'b1;
    // Random live flags, open loads must never disable anything
    for (int i = 0; i < 40; i++) begin
      r = lfsr(r);
      open_raw_a = r[0];
      open_raw_b = r[1];
      prewarn_raw = r[2];
      speed_mode_on = r[3];
      speed_mode_stall = r[4];
      fullstep_on = r[5];
      quiet_mode_on = r[6];
      cs_actual = r[11:7];
      load_measure_value = (r[31:30] == 2'b00) ? 10'h000 : r[21:12];
      hs_drop_a = {1'b0, r[28:22]};
      sense_drop_b = {2'b00, r[29:24]};
      cyc(3);
      chk({31'h0, bridge_disable}, 32'h0, "open load action");
      rd(`MDSF_ADDR_STATUS, exp_word());
    end
    hs_drop_a = 8'h00;
    sense_drop_b = 8'h00;
    prewarn_raw = 1'b0;
    // Open pins go quiet so a read right after a reset sees the synchroniser value
    open_raw_a = 1'b0;
    open_raw_b = 1'b0;
    // Step pulse clears standstill, timeout sets it again
    step_pin = 1'b1;
    cyc(2);
    step_pin = 1'b0;
    cyc(6);
    stst = 1'b0;
    rd(`MDSF_ADDR_STATUS, exp_word());
    cyc(20);
    stst = 1'b1;
    rd(`MDSF_ADDR_STATUS, exp_word());
    // Each short kind: set, clear refused while detected, latched after, cleared by disable
    for (int k = 0; k < 4; k++) begin
      set_det(k, 1'b0);
      cyc(4);
      chk({31'h0, bridge_disable}, 32'h0, "sum at threshold");
      set_det(k, 1'b1);
      cyc(4);
      lat_sh[k] = 1'b1;
      chk({31'h0, bridge_disable}, 32'h1, "short disables");
      rd(`MDSF_ADDR_STATUS, exp_word());
      drv_off(k, 1'b1);
      cyc(4);
      rd(`MDSF_ADDR_STATUS, exp_word());
      drv_off(k, 1'b0);
      // Enable pin passes its synchroniser before the supply compare drops
      cyc(4);
      set_det(k, 1'b0);
      cyc(4);
      rd(`MDSF_ADDR_STATUS, exp_word());
      drv_off(k, 1'b1);
      cyc(4);
      lat_sh[k] = 1'b0;
      rd(`MDSF_ADDR_STATUS, exp_word());
      chk({31'h0, bridge_disable}, 32'h0, "short cleared");
      drv_off(k, 1'b0);
      hs_drop_a = 8'h00;
      hs_drop_b = 8'h00;
      sense_drop_a = 8'h00;
      sense_drop_b = 8'h00;
      cyc(4);
    end
    // Overtemperature holds until prewarning also clears
    thermal_raw = 1'b1;
    prewarn_raw = 1'b1;
    cyc(4);
    lat_ot = 1'b1;
    rd(`MDSF_ADDR_STATUS, exp_word());
    thermal_raw = 1'b0;
    cyc(4);
    chk({31'h0, bridge_disable}, 32'h1, "thermal hold");
    rd(`MDSF_ADDR_STATUS, exp_word());
    prewarn_raw = 1'b0;
    cyc(4);
    lat_ot = 1'b0;
    chk({31'h0, bridge_disable}, 32'h0, "thermal release");
    rd(`MDSF_ADDR_STATUS, exp_word());
    // Reset in mid-run drops a live latch and restarts the idle count
    gnd_raw_a = 1'b1;
    cyc(5);
    rst_n = 1'b0;
    gnd_raw_a = 1'b0;
    cyc(2);
    chk({30'h0, rd_valid, bridge_disable}, 32'h0, "mid reset outputs");
    rst_n = 1'b1;
    stst = 1'b0;
    rd(`MDSF_ADDR_STATUS, exp_word());
    give_verdict();
  end
endmodule
